// ===== hw/eof_ctrl.sv
// Exposure, frame length and parallel output format control.
// Assumes a decoded byte register port, sync pins and a slow pixel strobe
// from the converter, all outside the reference clock domain except the
// register port.
`timescale 1ns/100ps
module eof_ctrl
  import eof_pkg::*;
(
  input wire logic ref_clk,
  input wire logic resetn,
  input wire logic [15:0] reg_addr,
  input wire logic [7:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic [7:0] reg_rdata_ff,
  input wire logic master_mode,
  input wire logic use_i2c,
  input wire logic vertical_sync_n_in,
  output logic vertical_sync_n_out_ff,
  output logic vertical_sync_n_oe_ff,
  input wire logic horizontal_sync_n_in,
  output logic horizontal_sync_n_out_ff,
  output logic horizontal_sync_n_oe_ff,
  output logic shutter_strobe_ff,
  output logic [15:0] integ_lines_ff,
  output logic readout_active_ff,
  input wire logic adc_clk,
  input wire logic [11:0] adc_data,
  output logic adc_ready_ff,
  output logic output_data_clock_ff,
  output logic [11:0] data_out_ff,
  output logic data_valid_ff
);

  // ---------------------------------------------------------------
  // Pin synchronisers
  // ---------------------------------------------------------------
  logic [2:0] vs_sync_ff;
  logic [2:0] hs_sync_ff;
  logic [2:0] ms_sync_ff;
  logic [2:0] i2c_sync_ff;
  logic [2:0] ack_sync_ff;
  eof_sync_type sync_now;
  logic vs_fall;
  logic hs_fall;
  logic adc_rise;
  logic is_master;
  logic is_i2c;

  // Three stages; a change counts when stages two and three differ
  always_ff @(posedge ref_clk or negedge resetn) begin
    if (!resetn) begin
      vs_sync_ff <= 3'h7;
      hs_sync_ff <= 3'h7;
      ms_sync_ff <= 3'h0;
      i2c_sync_ff <= 3'h0;
      ack_sync_ff <= 3'h0;
    end else begin
      vs_sync_ff <= {vs_sync_ff[1:0], vertical_sync_n_in};
      hs_sync_ff <= {hs_sync_ff[1:0], horizontal_sync_n_in};
      ms_sync_ff <= {ms_sync_ff[1:0], master_mode};
      i2c_sync_ff <= {i2c_sync_ff[1:0], use_i2c};
      ack_sync_ff <= {ack_sync_ff[1:0], adc_clk};
    end
  end

  assign sync_now = '{vs_n: vs_sync_ff[1], hs_n: hs_sync_ff[1]};
  assign vs_fall = vs_sync_ff[2] && !sync_now.vs_n;
  assign hs_fall = hs_sync_ff[2] && !sync_now.hs_n;
  assign adc_rise = !ack_sync_ff[2] && ack_sync_ff[1];
  assign is_master = ms_sync_ff[2];
  assign is_i2c = i2c_sync_ff[2];

  // ---------------------------------------------------------------
  // Register file
  // ---------------------------------------------------------------
  logic [15:0] frame_line_count_ff;
  logic [15:0] shutter_sweep_line_ff;
  logic [7:0] flc_pend_ff;
  logic [7:0] shs_pend_ff;
  logic [7:0] gradation_select_ff;
  logic [7:0] gradation_select_a_i2c_ff;
  logic [7:0] gradation_select_b_i2c_ff;
  logic [7:0] clock_edge_select_ff;
  logic [7:0] nxt_rdata;
  logic mode12;
  logic launch_rising;

  // Frame-line pair: first byte staged, second byte commits both
  always_ff @(posedge ref_clk or negedge resetn) begin
    if (!resetn) begin
      frame_line_count_ff <= RST_FRAME_LINES;
      flc_pend_ff <= 8'h00;
    end else if (reg_wr) begin
      if (reg_addr == ADDR_FLC_LO || reg_addr == ADDR_FLC_I2C_HI) begin
        flc_pend_ff <= reg_wdata;
      end else if (reg_addr == ADDR_FLC_HI) begin
        frame_line_count_ff <= {reg_wdata, flc_pend_ff};
      end else if (reg_addr == ADDR_FLC_I2C_LO) begin
        frame_line_count_ff <= {flc_pend_ff, reg_wdata};
      end
    end
  end

  // Shutter pair: same staging as the frame-line pair
  always_ff @(posedge ref_clk or negedge resetn) begin
    if (!resetn) begin
      shutter_sweep_line_ff <= RST_SHUTTER;
      shs_pend_ff <= 8'h00;
    end else if (reg_wr) begin
      if (reg_addr == ADDR_SHS_LO || reg_addr == ADDR_SHS_I2C_HI) begin
        shs_pend_ff <= reg_wdata;
      end else if (reg_addr == ADDR_SHS_HI) begin
        shutter_sweep_line_ff <= {reg_wdata, shs_pend_ff};
      end else if (reg_addr == ADDR_SHS_I2C_LO) begin
        shutter_sweep_line_ff <= {shs_pend_ff, reg_wdata};
      end
    end
  end

  // Output format bytes
  always_ff @(posedge ref_clk or negedge resetn) begin
    if (!resetn) begin
      gradation_select_ff <= RST_GRAD;
      gradation_select_a_i2c_ff <= RST_GRAD_I2C;
      gradation_select_b_i2c_ff <= RST_GRAD_I2C;
      clock_edge_select_ff <= RST_EDGE;
    end else if (reg_wr) begin
      if (reg_addr == ADDR_GRAD) begin
        gradation_select_ff <= reg_wdata;
      end else if (reg_addr == ADDR_GRAD_A_I2C) begin
        gradation_select_a_i2c_ff <= reg_wdata;
      end else if (reg_addr == ADDR_GRAD_B_I2C) begin
        gradation_select_b_i2c_ff <= reg_wdata;
      end else if (reg_addr == ADDR_EDGE || reg_addr == ADDR_EDGE_I2C) begin
        clock_edge_select_ff <= reg_wdata;
      end
    end
  end

  // Effective format from the active register port
  assign mode12 = is_i2c ? (gradation_select_b_i2c_ff == GRAD_CODE_12)
                         : gradation_select_ff[GRAD_BIT];
  assign launch_rising = clock_edge_select_ff[EDGE_BIT];

  // Read decode; unmapped addresses read zero
  always_comb begin
    nxt_rdata = 8'h00;
    if (reg_addr == ADDR_FLC_LO || reg_addr == ADDR_FLC_I2C_LO) begin
      nxt_rdata = frame_line_count_ff[7:0];
    end else if (reg_addr == ADDR_FLC_HI || reg_addr == ADDR_FLC_I2C_HI) begin
      nxt_rdata = frame_line_count_ff[15:8];
    end else if (reg_addr == ADDR_SHS_LO || reg_addr == ADDR_SHS_I2C_LO) begin
      nxt_rdata = shutter_sweep_line_ff[7:0];
    end else if (reg_addr == ADDR_SHS_HI || reg_addr == ADDR_SHS_I2C_HI) begin
      nxt_rdata = shutter_sweep_line_ff[15:8];
    end else if (reg_addr == ADDR_GRAD) begin
      nxt_rdata = gradation_select_ff;
    end else if (reg_addr == ADDR_GRAD_A_I2C) begin
      nxt_rdata = gradation_select_a_i2c_ff;
    end else if (reg_addr == ADDR_GRAD_B_I2C) begin
      nxt_rdata = gradation_select_b_i2c_ff;
    end else if (reg_addr == ADDR_EDGE || reg_addr == ADDR_EDGE_I2C) begin
      nxt_rdata = clock_edge_select_ff;
    end
  end

  // Read data register
  always_ff @(posedge ref_clk or negedge resetn) begin
    if (!resetn) begin
      reg_rdata_ff <= 8'h00;
    end else if (reg_rd) begin
      reg_rdata_ff <= nxt_rdata;
    end
  end

  // ---------------------------------------------------------------
  // Line and frame timing
  // ---------------------------------------------------------------
  logic [15:0] h_cnt_ff;
  logic [15:0] line_ff;
  logic [15:0] act_lines_ff;
  logic [15:0] act_shutter_ff;
  logic line_tick;
  logic frame_tick;
  logic m_line_end;
  logic m_frame_end;
  logic m_run_ff;

  // Master timebase end points
  assign m_line_end = (h_cnt_ff == 16'(LINE_CYCLES - 1));
  assign m_frame_end = m_line_end && (line_ff + 16'h0001 >= act_lines_ff);

  // Line and frame events from either timing source
  assign line_tick = is_master ? m_line_end : hs_fall;
  assign frame_tick = is_master ? m_frame_end : vs_fall;

  // Position within the line
  always_ff @(posedge ref_clk or negedge resetn) begin
    if (!resetn) begin
      h_cnt_ff <= 16'h0000;
    end else if (line_tick) begin
      h_cnt_ff <= 16'h0000;
    end else if (h_cnt_ff != 16'hffff) begin
      h_cnt_ff <= h_cnt_ff + 16'h0001;
    end
  end

  // Line within the frame; slave counts incoming line periods
  always_ff @(posedge ref_clk or negedge resetn) begin
    if (!resetn) begin
      line_ff <= 16'h0000;
    end else if (frame_tick) begin
      line_ff <= 16'h0000;
    end else if (line_tick && line_ff != 16'hffff) begin
      line_ff <= line_ff + 16'h0001;
    end
  end

  // Frame-boundary latch of shutter, and of length in master mode
  always_ff @(posedge ref_clk or negedge resetn) begin
    if (!resetn) begin
      act_lines_ff <= RST_FRAME_LINES;
      act_shutter_ff <= RST_SHUTTER;
    end else if (frame_tick) begin
      act_shutter_ff <= shutter_sweep_line_ff;
      act_lines_ff <= frame_line_count_ff;
    end else if (!is_master) begin
      act_lines_ff <= frame_line_count_ff;
    end
  end

  // Integration length in whole lines for the frame now exposing
  always_ff @(posedge ref_clk or negedge resetn) begin
    if (!resetn) begin
      integ_lines_ff <= RST_FRAME_LINES - RST_SHUTTER;
    end else if (frame_tick) begin
      if (is_master) begin
        integ_lines_ff <= frame_line_count_ff - shutter_sweep_line_ff;
      end else begin
        integ_lines_ff <= line_ff + 16'h0001 - shutter_sweep_line_ff;
      end
    end
  end

  // Shutter sweep 0.3 line into line N
  always_ff @(posedge ref_clk or negedge resetn) begin
    if (!resetn) begin
      shutter_strobe_ff <= 1'b0;
    end else begin
      shutter_strobe_ff <= (line_ff == act_shutter_ff) && !line_tick &&
                           (h_cnt_ff == 16'(SHUT_FRAC_CYCLES));
    end
  end

  // Readout rows first, blanking takes every extra line
  always_ff @(posedge ref_clk or negedge resetn) begin
    if (!resetn) begin
      readout_active_ff <= 1'b0;
    end else begin
      readout_active_ff <= (line_ff < READOUT_LINES);
    end
  end

  // Master sync outputs; pins released in slave mode
  always_ff @(posedge ref_clk or negedge resetn) begin
    if (!resetn) begin
      horizontal_sync_n_out_ff <= 1'b1;
      vertical_sync_n_out_ff <= 1'b1;
      horizontal_sync_n_oe_ff <= 1'b0;
      vertical_sync_n_oe_ff <= 1'b0;
      m_run_ff <= 1'b0;
    end else begin
      horizontal_sync_n_oe_ff <= is_master;
      vertical_sync_n_oe_ff <= is_master;
      m_run_ff <= is_master && (m_run_ff || m_frame_end);
      horizontal_sync_n_out_ff <= !(m_run_ff &&
                                    h_cnt_ff < 16'(HS_WIDTH_CYCLES));
      vertical_sync_n_out_ff <= !(m_run_ff && line_ff == 16'h0000 &&
                                  h_cnt_ff < 16'(HS_WIDTH_CYCLES));
    end
  end

  // ---------------------------------------------------------------
  // Pixel capture and buffering
  // ---------------------------------------------------------------
  eof_pix_type cap_pix;
  eof_pix_type fifo_pix;
  logic fifo_s_ready;
  logic fifo_m_valid;
  logic fifo_pop;

  assign cap_pix = '{code: adc_data};

  // Ready seen by the converter
  always_ff @(posedge ref_clk or negedge resetn) begin
    if (!resetn) begin
      adc_ready_ff <= 1'b0;
    end else begin
      adc_ready_ff <= fifo_s_ready;
    end
  end

  eof_fifo #(
    .WIDTH($bits(eof_pix_type)),
    .DEPTH(FIFO_DEPTH)
  ) u_fifo (
    .ref_clk(ref_clk),
    .resetn(resetn),
    .s_valid(adc_rise && adc_ready_ff),
    .s_ready(fifo_s_ready),
    .s_data(cap_pix),
    .m_valid(fifo_m_valid),
    .m_ready(fifo_pop),
    .m_data(fifo_pix)
  );

  // ---------------------------------------------------------------
  // Output clock and formatting
  // ---------------------------------------------------------------
  logic [7:0] div_ff;
  logic fall_now;
  logic rise_now;
  logic launch;
  logic [11:0] nxt_code;

  // Output clock divider: high in the first half period
  always_ff @(posedge ref_clk or negedge resetn) begin
    if (!resetn) begin
      div_ff <= 8'h00;
      output_data_clock_ff <= 1'b0;
    end else begin
      if (div_ff == 8'(OUT_CLK_CYCLES - 1)) begin
        div_ff <= 8'h00;
      end else begin
        div_ff <= div_ff + 8'h01;
      end
      output_data_clock_ff <= (div_ff < 8'(OUT_CLK_CYCLES / 2));
    end
  end

  // Launch on the selected clock edge
  assign rise_now = (div_ff == 8'h00);
  assign fall_now = (div_ff == 8'(OUT_CLK_CYCLES / 2));
  assign launch = launch_rising ? rise_now : fall_now;
  assign fifo_pop = launch && readout_active_ff;

  // Clip to the top code and map onto the pins
  always_comb begin
    nxt_code = 12'h000;
    if (mode12) begin
      nxt_code = (fifo_pix.code > MAX_CODE_12) ? MAX_CODE_12 : fifo_pix.code;
    end else if (fifo_pix.code[11:2] > MAX_CODE_10) begin
      nxt_code = {MAX_CODE_10, 2'b00};
    end else begin
      nxt_code = {fifo_pix.code[11:2], 2'b00};
    end
  end

  // Pin data register, changed only at a launch edge
  always_ff @(posedge ref_clk or negedge resetn) begin
    if (!resetn) begin
      data_out_ff <= 12'h000;
      data_valid_ff <= 1'b0;
    end else if (launch) begin
      data_valid_ff <= fifo_pop && fifo_m_valid;
      if (fifo_pop && fifo_m_valid) begin
        data_out_ff <= nxt_code;
      end
    end
  end

endmodule

// ===== hw/eof_fifo.sv
// Small synchronous FIFO with a registered output stage.
// Assumes one clock and an active-low asynchronous reset.
`timescale 1ns/100ps
module eof_fifo #(
  parameter int WIDTH = 12,
  parameter int DEPTH = 16
) (
  input wire logic ref_clk,
  input wire logic resetn,
  input wire logic s_valid,
  output logic s_ready,
  input wire logic [WIDTH-1:0] s_data,
  output logic m_valid,
  input wire logic m_ready,
  output logic [WIDTH-1:0] m_data
);
  localparam int AW = $clog2(DEPTH);

  logic [WIDTH-1:0] mem_ff [DEPTH];
  logic [AW-1:0] wr_ptr_ff;
  logic [AW-1:0] rd_ptr_ff;
  logic [AW:0] count_ff;
  logic out_valid_ff;
  logic [WIDTH-1:0] out_data_ff;
  logic push;
  logic pop;

  // Handshakes on both sides
  assign s_ready = (count_ff < (AW+1)'(DEPTH));
  assign push = s_valid && s_ready;
  assign pop = (count_ff != '0) && (!out_valid_ff || m_ready);
  assign m_valid = out_valid_ff;
  assign m_data = out_data_ff;

  // Storage write
  always_ff @(posedge ref_clk) begin
    if (push) begin
      mem_ff[wr_ptr_ff] <= s_data;
    end
  end

  // Pointers and fill level
  always_ff @(posedge ref_clk or negedge resetn) begin
    if (!resetn) begin
      wr_ptr_ff <= '0;
      rd_ptr_ff <= '0;
      count_ff <= '0;
    end else begin
      if (push) begin
        wr_ptr_ff <= wr_ptr_ff + 1'b1;
      end
      if (pop) begin
        rd_ptr_ff <= rd_ptr_ff + 1'b1;
      end
      count_ff <= count_ff + (AW+1)'(push) - (AW+1)'(pop);
    end
  end

  // Registered read stage
  always_ff @(posedge ref_clk or negedge resetn) begin
    if (!resetn) begin
      out_valid_ff <= 1'b0;
      out_data_ff <= '0;
    end else if (pop) begin
      out_valid_ff <= 1'b1;
      out_data_ff <= mem_ff[rd_ptr_ff];
    end else if (m_ready) begin
      out_valid_ff <= 1'b0;
    end
  end

endmodule

// ===== hw/eof_pkg.sv
// Shared constants and types for the exposure and output format block.
// Assumes a 125 MHz reference clock and a byte-wide decoded register port.
package eof_pkg;

  // ---------------------------------------------------------------
  // Register byte addresses (short and long address spaces)
  // ---------------------------------------------------------------
  localparam logic [15:0] ADDR_FLC_LO = 16'h0005;
  localparam logic [15:0] ADDR_FLC_HI = 16'h0006;
  localparam logic [15:0] ADDR_SHS_LO = 16'h0008;
  localparam logic [15:0] ADDR_SHS_HI = 16'h0009;
  localparam logic [15:0] ADDR_GRAD = 16'h0012;
  localparam logic [15:0] ADDR_EDGE = 16'h002d;
  localparam logic [15:0] ADDR_GRAD_A_I2C = 16'h0112;
  localparam logic [15:0] ADDR_GRAD_B_I2C = 16'h0113;
  localparam logic [15:0] ADDR_SHS_I2C_HI = 16'h0202;
  localparam logic [15:0] ADDR_SHS_I2C_LO = 16'h0203;
  localparam logic [15:0] ADDR_EDGE_I2C = 16'h302d;
  localparam logic [15:0] ADDR_FLC_I2C_HI = 16'h0340;
  localparam logic [15:0] ADDR_FLC_I2C_LO = 16'h0341;

  // ---------------------------------------------------------------
  // Reset values and field positions
  // ---------------------------------------------------------------
  localparam logic [15:0] RST_FRAME_LINES = 16'h04e2;
  localparam logic [15:0] RST_SHUTTER = 16'h0000;
  localparam logic [7:0] RST_GRAD = 8'h00;
  localparam logic [7:0] RST_EDGE = 8'h00;
  localparam logic [7:0] RST_GRAD_I2C = 8'h0a;
  localparam int GRAD_BIT = 1;
  localparam int EDGE_BIT = 1;
  localparam logic [7:0] GRAD_CODE_12 = 8'h0c;
  localparam logic [9:0] MAX_CODE_10 = 10'h3fe;
  localparam logic [11:0] MAX_CODE_12 = 12'hffe;

  // ---------------------------------------------------------------
  // Timing
  // ---------------------------------------------------------------
  localparam int REF_CLK_MHZ = 125;
  localparam int LINE_TIME_NS = 29630;
  localparam int LINE_CYCLES = (LINE_TIME_NS * REF_CLK_MHZ) / 1000;
  localparam int SHUT_FRAC_CYCLES = (LINE_CYCLES * 3) / 10;
  localparam int HS_WIDTH_NS = 1000;
  localparam int HS_WIDTH_CYCLES = (HS_WIDTH_NS * REF_CLK_MHZ) / 1000;
  localparam int OUT_CLK_NS = 128;
  localparam int OUT_CLK_CYCLES = (OUT_CLK_NS * REF_CLK_MHZ) / 1000;
  localparam logic [15:0] READOUT_LINES = 16'd1121;
  localparam int FIFO_DEPTH = 16;

  // ---------------------------------------------------------------
  // Carriers
  // ---------------------------------------------------------------
  typedef struct packed {
    logic [11:0] code;
  } eof_pix_type;

  typedef struct packed {
    logic vs_n;
    logic hs_n;
  } eof_sync_type;

endpackage

// ===== test/eof_ctrl_asserts.sv
// Port checks for the exposure and output format block.
// Assumes binding onto eof_ctrl; one domain on ref_clk.
`timescale 1ns/100ps
module eof_ctrl_asserts
  import eof_pkg::*;
(
  input wire logic ref_clk,
  input wire logic resetn,
  input wire logic master_mode,
  input wire logic vertical_sync_n_out_ff,
  input wire logic vertical_sync_n_oe_ff,
  input wire logic horizontal_sync_n_out_ff,
  input wire logic horizontal_sync_n_oe_ff,
  input wire logic shutter_strobe_ff,
  input wire logic output_data_clock_ff,
  input wire logic [11:0] data_out_ff,
  input wire logic data_valid_ff
);
  logic hs_prev_ff;
  logic hs_seen_ff;
  logic [15:0] hs_cnt_ff;
  logic hs_fall;
  logic hs_rise;

  default clocking cb @(posedge ref_clk);
  endclocking
  default disable iff (!resetn);

  // ----------
  // Line tracking
  // ----------
  // Edges of the driven line sync
  assign hs_fall = hs_prev_ff & ~horizontal_sync_n_out_ff;
  assign hs_rise = ~hs_prev_ff & horizontal_sync_n_out_ff;

  // Cycles since the last line sync fall
  always_ff @(posedge ref_clk or negedge resetn) begin
    if (!resetn) begin
      hs_prev_ff <= 1'b1;
      hs_seen_ff <= 1'b0;
      hs_cnt_ff <= 16'h0000;
    end else begin
      hs_prev_ff <= horizontal_sync_n_out_ff;
      hs_seen_ff <= horizontal_sync_n_oe_ff & (hs_seen_ff | hs_fall);
      hs_cnt_ff <= hs_fall ? 16'h0000 : hs_cnt_ff + 16'h0001;
    end
  end

  // ----------
  // Checks
  // ----------
  sequence vs_start_s;
    $fell(vertical_sync_n_out_ff) && vertical_sync_n_oe_ff;
  endsequence
  sequence dclk_high_s;
    output_data_clock_ff [*8] ##1 !output_data_clock_ff;
  endsequence

  a_sync_slave_off: assert property ((!master_mode) [*6] |->
    !horizontal_sync_n_oe_ff && !vertical_sync_n_oe_ff) else $error("sync driven in slave");
  a_sync_master_on: assert property (master_mode [*6] |->
    horizontal_sync_n_oe_ff && vertical_sync_n_oe_ff) else $error("sync idle in master");
  a_frame_line_start: assert property (vs_start_s |-> hs_fall)
    else $error("frame sync without line sync");
  a_line_len: assert property (hs_fall && hs_seen_ff |-> hs_cnt_ff == LINE_CYCLES - 1)
    else $error("line period wrong");
  a_hs_width: assert property (hs_rise && hs_seen_ff |-> hs_cnt_ff == HS_WIDTH_CYCLES - 1)
    else $error("line sync width wrong");
  a_strobe_single: assert property (shutter_strobe_ff |=> !shutter_strobe_ff [*8])
    else $error("shutter strobe repeated");
  a_code_clip: assert property (data_valid_ff |-> data_out_ff != 12'hfff)
    else $error("output code not clipped");
  a_launch_only: assert property (!$stable(data_out_ff) |-> !$stable(output_data_clock_ff))
    else $error("data changed off a clock edge");
  a_dclk_half: assert property ($rose(output_data_clock_ff) |-> dclk_high_s)
    else $error("output clock high phase wrong");
endmodule

bind eof_ctrl eof_ctrl_asserts eof_ctrl_asserts_inst (
  .ref_clk(ref_clk),
  .resetn(resetn),
  .master_mode(master_mode),
  .vertical_sync_n_out_ff(vertical_sync_n_out_ff),
  .vertical_sync_n_oe_ff(vertical_sync_n_oe_ff),
  .horizontal_sync_n_out_ff(horizontal_sync_n_out_ff),
  .horizontal_sync_n_oe_ff(horizontal_sync_n_oe_ff),
  .shutter_strobe_ff(shutter_strobe_ff),
  .output_data_clock_ff(output_data_clock_ff),
  .data_out_ff(data_out_ff),
  .data_valid_ff(data_valid_ff)
);

// ===== test/eof_ctrl_tb.sv
// Self-checking bench for the exposure and output format block.
// Assumes the pixel strobe is stepped by hand at 160 ns.
`timescale 1ns/100ps
module eof_ctrl_tb
  import eof_pkg::*;
;
  localparam logic [15:0] RA [13] = '{ADDR_FLC_LO, ADDR_FLC_HI, ADDR_SHS_LO, ADDR_SHS_HI,
    ADDR_GRAD, ADDR_EDGE, ADDR_GRAD_A_I2C, ADDR_GRAD_B_I2C, ADDR_FLC_I2C_HI,
    ADDR_FLC_I2C_LO, ADDR_SHS_I2C_HI, ADDR_EDGE_I2C, 16'h0077};
  localparam logic [7:0] RV [13] = '{8'he2, 8'h04, 8'h00, 8'h00, 8'h00, 8'h00, 8'h0a,
    8'h0a, 8'h04, 8'he2, 8'h00, 8'h00, 8'h00};
  localparam logic [11:0] PIX [4] = '{12'h123, 12'hfff, 12'h000, 12'habd};
  logic ref_clk, resetn, reg_wr, reg_rd, master_mode, use_i2c, tb_vs_n, tb_hs_n;
  logic vs_w, hs_w, vs_out, vs_oe, hs_out, hs_oe, strobe, readout, adc_clk, adc_ready;
  logic dclk, dvalid, edge_rise;
  logic [15:0] reg_addr, integ;
  logic [7:0] reg_wdata, rdata;
  logic [11:0] adc_data, dout;
  int num_errors = 0;
  int num_checks = 0;
  int cycles = 0;

  // Resolved sync pins
  assign vs_w = vs_oe ? vs_out : tb_vs_n;
  assign hs_w = hs_oe ? hs_out : tb_hs_n;

  eof_ctrl eof_ctrl_inst (.ref_clk(ref_clk), .resetn(resetn), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata_ff(rdata),
    .master_mode(master_mode), .use_i2c(use_i2c), .vertical_sync_n_in(vs_w),
    .vertical_sync_n_out_ff(vs_out), .vertical_sync_n_oe_ff(vs_oe),
    .horizontal_sync_n_in(hs_w), .horizontal_sync_n_out_ff(hs_out),
    .horizontal_sync_n_oe_ff(hs_oe), .shutter_strobe_ff(strobe), .integ_lines_ff(integ),
    .readout_active_ff(readout), .adc_clk(adc_clk), .adc_data(adc_data),
    .adc_ready_ff(adc_ready), .output_data_clock_ff(dclk), .data_out_ff(dout),
    .data_valid_ff(dvalid));
  eof_isp_model eof_isp_model_inst (.dclk(dclk), .pins(dout), .valid(dvalid),
    .rise_capture(edge_rise));

  // ----------
  // Shared tasks
  // ----------
  task automatic stop_test();
    $display("checks %0d mismatches %0d", num_checks, num_errors);
    if (num_errors == 0 && num_checks > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask

  task automatic check(input string what, input logic [15:0] exp, input logic [15:0] got);
    num_checks++;
    if (got !== exp) begin
      num_errors++;
      $display("BAD %s expected %h seen %h", what, exp, got);
    end
  endtask

  task automatic wr(input logic [15:0] a, input logic [7:0] d);
    @(posedge ref_clk);
    reg_addr <= a;
    reg_wdata <= d;
    reg_wr <= 1'b1;
    @(posedge ref_clk);
    reg_wr <= 1'b0;
  endtask

  task automatic rd_check(input logic [15:0] a, input logic [7:0] exp);
    @(posedge ref_clk);
    reg_addr <= a;
    reg_rd <= 1'b1;
    @(posedge ref_clk);
    reg_rd <= 1'b0;
    @(posedge ref_clk);
    #1 check("register byte", {8'h00, exp}, {8'h00, rdata});
  endtask

  // Counts line syncs up to the next frame sync
  task automatic frame(output int lines, output int sline);
    int n;
    logic pv, ph;
    lines = 0;
    sline = -1;
    pv = vs_w;
    ph = hs_w;
    for (n = 0; n < 16000; n++) begin
      @(posedge ref_clk);
      #1;
      if (ph && !hs_w) lines++;
      if (strobe) sline = lines;
      if (pv && !vs_w) return;
      pv = vs_w;
      ph = hs_w;
    end
    check("frame sync seen", 16'd1, 16'd0);
  endtask

  // ----------
  // Scenarios
  // ----------
  task automatic test_regs();
    int i;
    for (i = 0; i < 13; i++) rd_check(RA[i], RV[i]);
    wr(ADDR_FLC_LO, 8'hff);
    rd_check(ADDR_FLC_LO, 8'he2);
    wr(ADDR_FLC_HI, 8'hff);
    rd_check(ADDR_FLC_LO, 8'hff);
    rd_check(ADDR_FLC_HI, 8'hff);
    wr(ADDR_FLC_I2C_HI, 8'h12);
    wr(ADDR_FLC_I2C_LO, 8'h34);
    rd_check(ADDR_FLC_I2C_HI, 8'h12);
    wr(ADDR_SHS_I2C_HI, 8'h00);
    wr(ADDR_SHS_I2C_LO, 8'h01);
    rd_check(ADDR_SHS_LO, 8'h01);
    wr(16'h0077, 8'h55);
    rd_check(16'h0077, 8'h00);
    $display("test regs done");
  endtask

  task automatic test_master();
    int m, s;
    wr(ADDR_FLC_LO, 8'h03);
    wr(ADDR_FLC_HI, 8'h00);
    master_mode <= 1'b1;
    frame(m, s);
    frame(m, s);
    check("lines per frame", 16'd3, 16'(m));
    check("shutter line", 16'd1, 16'(s));
    repeat (4) @(posedge ref_clk);
    check("integ lines", 16'd2, integ);
    wr(ADDR_SHS_LO, 8'h02);
    wr(ADDR_SHS_HI, 8'h00);
    repeat (4) @(posedge ref_clk);
    check("integ held", 16'd2, integ);
    frame(m, s);
    repeat (4) @(posedge ref_clk);
    check("integ next frame", 16'd1, integ);
    $display("test master done");
  endtask

  task automatic test_pixels();
    logic [11:0] e;
    logic [9:0] t;
    int p, i;
    for (p = 0; p < 3; p++) begin
      use_i2c <= (p != 0);
      wr(ADDR_GRAD, (p == 0) ? 8'h02 : 8'h00);
      wr(ADDR_GRAD_B_I2C, (p == 2) ? GRAD_CODE_12 : RST_GRAD_I2C);
      wr(ADDR_EDGE, (p == 1) ? 8'h02 : 8'h00);
      edge_rise = (p != 1);
      repeat (40) @(posedge ref_clk);
      eof_isp_model_inst.got_q.delete();
      #3;
      for (i = 0; i < 4; i++) begin
        adc_data <= PIX[i];
        #80 adc_clk <= 1'b1;
        #80 adc_clk <= 1'b0;
      end
      repeat (100) @(posedge ref_clk);
      check("pixel count", 16'd4, 16'(eof_isp_model_inst.got_q.size()));
      for (i = 0; i < 4; i++) begin
        t = (PIX[i][11:2] > 10'h3fe) ? 10'h3fe : PIX[i][11:2];
        e = (p == 1) ? {t, 2'b00} : ((PIX[i] > 12'hffe) ? 12'hffe : PIX[i]);
        check("pins", {4'h0, e}, {4'h0, eof_isp_model_inst.got_q[i]});
      end
    end
    $display("test pixels done");
  endtask

  task automatic test_slave();
    int f, l;
    master_mode <= 1'b0;
    repeat (10) @(posedge ref_clk);
    check("sync drive", 16'd0, {14'd0, vs_oe, hs_oe});
    for (f = 0; f < 4; f++) begin
      for (l = 0; l < ((f < 2) ? 5 : 8); l++) begin
        tb_hs_n <= 1'b0;
        tb_vs_n <= (l != 0);
        repeat (4) @(posedge ref_clk);
        tb_hs_n <= 1'b1;
        tb_vs_n <= 1'b1;
        repeat (46) @(posedge ref_clk);
      end
      if (f == 2) check("slave integ", 16'd3, integ);
    end
    check("long frame integ", 16'd6, integ);
    $display("test slave done");
  endtask

  task automatic test_burst();
    int k;
    eof_isp_model_inst.got_q.delete();
    repeat (1130) begin
      tb_hs_n <= 1'b0;
      repeat (2) @(posedge ref_clk);
      tb_hs_n <= 1'b1;
      repeat (2) @(posedge ref_clk);
    end
    #3 check("readout in blanking", 16'd0, {15'd0, readout});
    for (k = 0; k < 20; k++) begin
      adc_data <= 12'h100 + 12'(k);
      #80 adc_clk <= 1'b1;
      #80 adc_clk <= 1'b0;
    end
    check("ready when full", 16'd0, {15'd0, adc_ready});
    check("held in blanking", 16'd0, 16'(eof_isp_model_inst.got_q.size()));
    @(posedge ref_clk);
    tb_vs_n <= 1'b0;
    tb_hs_n <= 1'b0;
    repeat (4) @(posedge ref_clk);
    tb_vs_n <= 1'b1;
    tb_hs_n <= 1'b1;
    repeat (400) @(posedge ref_clk);
    #1 check("burst count", 16'd17, 16'(eof_isp_model_inst.got_q.size()));
    for (k = 0; k < 17; k++) begin
      check("burst word", 16'h100 + 16'(k), {4'h0, eof_isp_model_inst.got_q[k]});
    end
    check("ready after drain", 16'd1, {15'd0, adc_ready});
    $display("test burst done");
  endtask

  // ----------
  // Clock, ceiling and sequence
  // ----------
  initial begin
    ref_clk = 1'b0;
    forever #4 ref_clk = ~ref_clk;
  end

  // Cycle ceiling
  always @(posedge ref_clk) begin
    cycles++;
    if (cycles == 70000) begin
      num_errors++;
      $display("BAD timeout expected %0d seen %0d", 0, cycles);
      stop_test();
    end
  end

  // Main sequence
  initial begin
    resetn = 1'b0;
    reg_addr = 16'h0000;
    reg_wdata = 8'h00;
    reg_wr = 1'b0;
    reg_rd = 1'b0;
    master_mode = 1'b0;
    use_i2c = 1'b0;
    tb_vs_n = 1'b1;
    tb_hs_n = 1'b1;
    adc_clk = 1'b0;
    adc_data = 12'h000;
    edge_rise = 1'b1;
    repeat (3) @(posedge ref_clk);
    resetn <= 1'b1;
    test_regs();
    test_master();
    test_pixels();
    test_slave();
    test_burst();
    stop_test();
  end
endmodule

// ===== test/eof_isp_model.sv
// Receiving processor model for the parallel pixel bus.
// Assumes capture on the edge opposite to the launch edge.
`timescale 1ns/100ps
module eof_isp_model
  import eof_pkg::*;
(
  input wire logic dclk,
  input wire logic [11:0] pins,
  input wire logic valid,
  input wire logic rise_capture
);
  eof_pix_type got_q[$];

  // Capture on rising edge for falling launch
  always @(posedge dclk) begin
    if (rise_capture && valid) begin
      got_q.push_back(pins);
    end
  end

  // Capture on falling edge for rising launch
  always @(negedge dclk) begin
    if (!rise_capture && valid) begin
      got_q.push_back(pins);
    end
  end
endmodule
